// [common/elapsed_counter_pkg.sv]
// constants shared by the elapsed counter serial port
// assumes one system clock domain and one serial clock domain
package elapsed_counter_pkg;

  // =====================================================================
  // command byte layout
  localparam int CMD_W           = 8;
  localparam int SEL_CONT_BIT    = 7;
  localparam int SEL_PWR_BIT     = 6;
  localparam int TRIM_HI_BIT     = 5;
  localparam int TRIM_LO_BIT     = 3;
  localparam int CLR_CONT_BIT    = 2;
  localparam int CLR_PWR_BIT     = 1;
  localparam int READ_BIT        = 0;

  // =====================================================================
  // sizes, reset values, timing
  localparam int CNT_W           = 32;
  localparam int TRIM_W          = 3;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 3'h3;
  localparam int CRYSTAL_HZ      = 32768;
  localparam int TICK_HZ         = 1;
  localparam int PRESCALE        = CRYSTAL_HZ / TICK_HZ;
  localparam int EVT_FIFO_DEPTH  = 32;
  localparam int EVT_W           = CMD_W + CNT_W;

  typedef enum logic [1:0] {
    PH_CMD,
    PH_RDATA,
    PH_WDATA,
    PH_DONE
  } phase_e;

endpackage

// [hw/elapsed_counter_port.sv]
// serial port, counters and event buffer of the elapsed counter
// assumes host keeps the enable high for a whole exchange and the
// serial clock only toggles while the enable is high
`timescale 1ns/1ps

// =======================================================================
// event fifo
module evt_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
    $error("evt_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// =======================================================================
// top
module elapsed_counter_port #(
  parameter int PRESCALE_CNT = elapsed_counter_pkg::PRESCALE,
  parameter int FIFO_DEPTH   = elapsed_counter_pkg::EVT_FIFO_DEPTH
) (
  // system clock and reset
  input  wire logic                               clk_sys,
  input  wire logic                               srst,
  // serial link
  input  wire logic                               xfer_en,
  input  wire logic                               sclk,
  input  wire logic                               dq_in,
  output logic                                    dq_out,
  output logic                                    dq_oe,
  // supply and oscillator
  input  wire logic                               access_inhibit,
  input  wire logic                               vcc_valid,
  input  wire logic                               crystal_in,
  // status
  output logic [elapsed_counter_pkg::TRIM_W-1:0]  osc_trim,
  output logic [elapsed_counter_pkg::CNT_W-1:0]   cont_count,
  output logic [elapsed_counter_pkg::CNT_W-1:0]   pwr_count,
  output logic                                    evt_overflow
);
  import elapsed_counter_pkg::*;

  if (PRESCALE_CNT < 2 || FIFO_DEPTH < 2) begin : g_bad_cfg
    $error("elapsed_counter_port: prescale and depth must be >= 2");
  end

  // =====================================================================
  // link domain: command and data shifting
  phase_e             phase;
  logic [5:0]         bit_cnt;
  logic [CMD_W-1:0]   cmd_sh;
  logic [CNT_W-1:0]   wr_sh;
  logic [CMD_W-1:0]   evt_cmd;
  logic [CNT_W-1:0]   evt_data;
  logic               evt_toggle;
  logic               inh_l1;
  logic               inh_l2;
  logic               inh_sys;
  logic [CNT_W-1:0]   snap;
  logic               cmd_evt;
  logic               wr_evt;
  logic [CMD_W-1:0]   next_cmd;
  logic [CNT_W-1:0]   next_wr;

  assign next_cmd = {cmd_sh[CMD_W-2:0], dq_in};
  assign next_wr  = {wr_sh[CNT_W-2:0], dq_in};

  // inhibit level brought onto the serial clock
  always_ff @(posedge sclk or negedge xfer_en) begin
    if (!xfer_en) begin
      inh_l1 <= 1'b0;
      inh_l2 <= 1'b0;
    end else begin
      inh_l1 <= inh_sys;
      inh_l2 <= inh_l1;
    end
  end

  // enable low clears the phase, bit count and shift registers of the link side
  always_ff @(posedge sclk or negedge xfer_en) begin
    if (!xfer_en) begin
      phase   <= PH_CMD;
      bit_cnt <= '0;
      cmd_sh  <= '0;
      wr_sh   <= '0;
    end else if (inh_l2) begin
      phase   <= PH_DONE;
    end else begin
      case (phase)
        PH_CMD: begin
          cmd_sh  <= next_cmd;
          bit_cnt <= bit_cnt + 6'h1;
          if (bit_cnt == 6'(CMD_W - 1)) begin
            bit_cnt <= '0;
            if (next_cmd[SEL_CONT_BIT] ^ next_cmd[SEL_PWR_BIT])
              phase <= next_cmd[READ_BIT] ? PH_RDATA : PH_WDATA;
            else
              phase <= PH_DONE;
          end
        end
        PH_RDATA, PH_WDATA: begin
          wr_sh   <= next_wr;
          bit_cnt <= bit_cnt + 6'h1;
          if (bit_cnt == 6'(CNT_W - 1))
            phase <= PH_DONE;
        end
        default: begin
          phase <= PH_DONE;
        end
      endcase
    end
  end

  // events handed to the system side; words held until the next event
  assign cmd_evt = phase == PH_CMD && bit_cnt == 6'(CMD_W - 1)
                   && !(next_cmd[SEL_CONT_BIT] ^ next_cmd[SEL_PWR_BIT]
                        && !next_cmd[READ_BIT]);
  assign wr_evt  = phase == PH_WDATA && bit_cnt == 6'(CNT_W - 1);
  // toggle cleared by srst only, which comes while the link is idle
  always_ff @(posedge sclk or posedge srst) begin
    if (srst)
      evt_toggle <= 1'b0;
    else if (xfer_en && !inh_l2 && (cmd_evt || wr_evt))
      evt_toggle <= ~evt_toggle;
  end
  always_ff @(posedge sclk) begin
    if (xfer_en && !inh_l2 && cmd_evt) begin
      evt_cmd  <= next_cmd;
    end else if (xfer_en && !inh_l2 && wr_evt) begin
      evt_cmd  <= cmd_sh;
      evt_data <= next_wr;
    end
  end

  // =====================================================================
  // link domain: read data on falling edges
  logic [CNT_W-1:0]   rd_sh;
  logic               rd_loaded;
  logic               drive;

  always_ff @(negedge sclk or negedge xfer_en) begin
    if (!xfer_en) begin
      rd_loaded <= 1'b0;
      rd_sh     <= '0;
      dq_out    <= 1'b0;
      drive     <= 1'b0;
    end else begin
      drive <= (phase == PH_RDATA) && !inh_l2;
      if (phase == PH_RDATA) begin
        if (!rd_loaded) begin
          rd_loaded <= 1'b1;
          dq_out    <= snap[0];
          rd_sh     <= {1'b0, snap[CNT_W-1:1]};
        end else begin
          dq_out    <= rd_sh[0];
          rd_sh     <= {1'b0, rd_sh[CNT_W-1:1]};
        end
      end
    end
  end

  // released at once when the clock rises or the enable drops
  assign dq_oe = drive & ~sclk & xfer_en;

  // =====================================================================
  // system domain: input synchronisers
  logic [2:0]         tg_s;
  logic [2:0]         inh_s;
  logic [2:0]         vcc_s;
  logic [2:0]         xtal_s;
  logic               tg_seen;
  logic               vcc_ok;
  logic               xtal_lvl;
  logic               xtal_prev;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tg_s   <= '0;
      inh_s  <= '0;
      vcc_s  <= '0;
      xtal_s <= '0;
    end else begin
      tg_s   <= {tg_s[1:0], evt_toggle};
      inh_s  <= {inh_s[1:0], access_inhibit};
      vcc_s  <= {vcc_s[1:0], vcc_valid};
      xtal_s <= {xtal_s[1:0], crystal_in};
    end
  end

  // a change counts once the second and third stages agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      inh_sys  <= 1'b0;
      vcc_ok   <= 1'b0;
      xtal_lvl <= 1'b0;
    end else begin
      if (inh_s[1] == inh_s[2])
        inh_sys <= inh_s[2];
      if (vcc_s[1] == vcc_s[2])
        vcc_ok <= vcc_s[2];
      if (xtal_s[1] == xtal_s[2])
        xtal_lvl <= xtal_s[2];
    end
  end

  // =====================================================================
  // system domain: event capture into the fifo
  logic               new_evt;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               fifo_out_ready;
  logic [EVT_W-1:0]   fifo_out_data;

  assign new_evt = (tg_s[1] == tg_s[2]) && (tg_s[2] != tg_seen);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tg_seen      <= 1'b0;
      evt_overflow <= 1'b0;
    end else begin
      if (new_evt)
        tg_seen <= tg_s[2];
      if (new_evt && !fifo_in_ready)
        evt_overflow <= 1'b1;
    end
  end

  evt_fifo #(
    .WIDTH (EVT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (new_evt && !inh_sys),
    .in_ready  (fifo_in_ready),
    .in_data   ({evt_cmd, evt_data}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // =====================================================================
  // system domain: 1 Hz tick from the crystal
  logic [$clog2(PRESCALE_CNT)-1:0] pre_cnt;
  logic                            tick;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pre_cnt   <= '0;
      tick      <= 1'b0;
      xtal_prev <= 1'b0;
    end else begin
      xtal_prev <= xtal_lvl;
      tick      <= 1'b0;
      if (osc_trim == '0) begin
        pre_cnt <= '0;
      end else if (xtal_lvl && !xtal_prev) begin
        if (pre_cnt == ($clog2(PRESCALE_CNT))'(PRESCALE_CNT - 1)) begin
          pre_cnt <= '0;
          tick    <= 1'b1;
        end else begin
          pre_cnt <= pre_cnt + 1'b1;
        end
      end
    end
  end

  // =====================================================================
  // system domain: command execution and counters
  logic [CMD_W-1:0]   ex_cmd;
  logic [CNT_W-1:0]   ex_data;
  logic               ex_cont;
  logic               ex_pwr;
  logic               ex_rd;

  // a tick cycle stalls the drain so count and load never collide
  assign fifo_out_ready = !tick;
  assign {ex_cmd, ex_data} = fifo_out_data;
  assign ex_cont = ex_cmd[SEL_CONT_BIT];
  assign ex_pwr  = ex_cmd[SEL_PWR_BIT];
  assign ex_rd   = ex_cmd[READ_BIT];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cont_count <= '0;
      pwr_count  <= '0;
      osc_trim   <= TRIM_RESET;
      snap       <= '0;
    end else if (tick) begin
      cont_count <= cont_count + 1'b1;
      if (vcc_ok)
        pwr_count <= pwr_count + 1'b1;
    end else if (fifo_out_valid) begin
      case ({ex_cont, ex_pwr})
        2'b10: begin
          if (ex_rd)
            snap <= cont_count;
          else
            cont_count <= ex_data;
        end
        2'b01: begin
          if (ex_rd)
            snap <= pwr_count;
          else
            pwr_count <= ex_data;
        end
        2'b00: begin
          if (ex_cmd[CLR_CONT_BIT])
            cont_count <= '0;
          if (ex_cmd[CLR_PWR_BIT])
            pwr_count <= '0;
        end
        2'b11: begin
          if (!ex_rd)
            osc_trim <= ex_cmd[TRIM_HI_BIT:TRIM_LO_BIT];
        end
        default: begin
          snap <= snap;
        end
      endcase
    end
  end
endmodule

// [tb/ecp_chk.sv]
// assertions on the elapsed counter port, bound to its top
// assumes each sclk half period spans several clk_sys cycles
`timescale 1ns/1ps
module ecp_chk
  import elapsed_counter_pkg::*;
#(
  parameter int PRESCALE_CNT = 32768,
  parameter int FIFO_DEPTH   = 32
) (
  // clock and reset
  input wire logic                                  clk_sys,
  input wire logic                                  srst,
  // serial link
  input wire logic                                  xfer_en,
  input wire logic                                  sclk,
  input wire logic                                  dq_in,
  input wire logic                                  dq_out,
  input wire logic                                  dq_oe,
  // supply and oscillator
  input wire logic                                  access_inhibit,
  input wire logic                                  vcc_valid,
  input wire logic                                  crystal_in,
  // status
  input wire logic [elapsed_counter_pkg::TRIM_W-1:0] osc_trim,
  input wire logic [elapsed_counter_pkg::CNT_W-1:0]  cont_count,
  input wire logic [elapsed_counter_pkg::CNT_W-1:0]  pwr_count,
  input wire logic                                  evt_overflow
);
  logic       sclk_d;
  logic [5:0] rise_cnt;
  logic [5:0] idle_cnt;
  logic [7:0] cmd_sh;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // =====================================================================
  // sclk edges, command and idle time seen at clk_sys rate
  always_ff @(posedge clk_sys) begin
    sclk_d <= sclk;
  end
  always_ff @(posedge clk_sys) begin
    if (srst || !xfer_en)
      rise_cnt <= '0;
    else if (sclk && !sclk_d && rise_cnt != 6'h3f)
      rise_cnt <= rise_cnt + 6'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (srst)
      cmd_sh <= '0;
    else if (xfer_en && sclk && !sclk_d && rise_cnt < 6'h08)
      cmd_sh <= {cmd_sh[6:0], dq_in};
  end
  always_ff @(posedge clk_sys) begin
    if (srst || xfer_en)
      idle_cnt <= '0;
    else if (idle_cnt != 6'h3f)
      idle_cnt <= idle_cnt + 6'h01;
  end
  // =====================================================================
  // assertions
  oe_sclk_low_a: assert property (dq_oe |-> !sclk && xfer_en)
    else $error("data driven while clock high or link off");
  oe_window_a: assert property (dq_oe |-> rise_cnt inside {[8:39]})
    else $error("data driven outside the 32 data clocks");
  first_bit_a: assert property ($fell(sclk) && rise_cnt == 6'h08
    && cmd_sh[0] && ^cmd_sh[7:6] && !access_inhibit |-> dq_oe)
    else $error("first read bit missing");
  oe_read_cmd_a: assert property (dq_oe |-> cmd_sh[0] && ^cmd_sh[7:6])
    else $error("data driven for a non-read command");
  inhibit_quiet_a: assert property
    (access_inhibit && $past(access_inhibit, 4) |-> !dq_oe)
    else $error("data driven while access inhibited");
  stopped_osc_a: assert property (idle_cnt == 6'h3f && osc_trim == 3'h0
    |=> $stable(cont_count) && $stable(pwr_count))
    else $error("counter moved with oscillator stopped");
  tick_step_a: assert property (idle_cnt == 6'h3f && $changed(cont_count)
    |-> cont_count == $past(cont_count) + 1)
    else $error("continuous counter stepped by other than one");
  pwr_gate_a: assert property (idle_cnt == 6'h3f && !vcc_valid
    && !$past(vcc_valid, 6) |=> $stable(pwr_count))
    else $error("powered counter moved without supply");
  trim_source_a: assert property ($changed(osc_trim)
    |-> cmd_sh[7:6] == 2'b11 && !cmd_sh[0])
    else $error("trim changed without a trim command");
  cover property (rise_cnt == 6'h27 && dq_oe);
  cover property ($changed(osc_trim));
  cover property (idle_cnt == 6'h3f && $changed(pwr_count));
endmodule

bind elapsed_counter_port ecp_chk #(
  .PRESCALE_CNT(PRESCALE_CNT), .FIFO_DEPTH(FIFO_DEPTH)) chk (
  .clk_sys(clk_sys), .srst(srst), .xfer_en(xfer_en), .sclk(sclk),
  .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
  .access_inhibit(access_inhibit), .vcc_valid(vcc_valid),
  .crystal_in(crystal_in), .osc_trim(osc_trim), .cont_count(cont_count),
  .pwr_count(pwr_count), .evt_overflow(evt_overflow));

// [tb/ecp_host.sv]
// host model driving the three-wire serial link
// assumes lclk is a free 12 ns time base that paces sclk
`timescale 1ns/1ps
module ecp_host (
  // time base
  input  wire logic lclk,
  // link
  output logic      xfer_en,
  output logic      sclk,
  output logic      dq_in,
  input  wire logic dq_out,
  input  wire logic dq_oe
);
  int   half_n = 8;
  logic dq_h = 1'b0;
  // released line shows the host level, toggled during reads
  assign dq_in = dq_oe ? dq_out : dq_h;
  // a falling enable at start clears the link side before any frame
  initial begin
    xfer_en = 1'b1;
    sclk = 1'b0;
    #1;
    xfer_en = 1'b0;
  end
  task automatic half();
    repeat (half_n) @(posedge lclk);
  endtask
  // =====================================================================
  // one frame: command msb first, then nd data clocks
  task automatic frame(input logic [7:0] cmd, input logic [31:0] wd,
                       input int nd, output logic [31:0] rd);
    logic [39:0] sh;
    sh = {cmd, wd};
    rd = '0;
    @(posedge lclk);
    xfer_en <= 1'b1;
    half();
    for (int i = 0; i < 8 + nd; i++) begin
      dq_h <= (i < 8 || !cmd[0]) ? sh[39-i] : ~dq_h;
      half();
      if (i >= 8)
        rd[i-8] = dq_oe ? dq_out : 1'bx;
      sclk <= 1'b1;
      half();
      if (i < 7 + nd)
        sclk <= 1'b0;
    end
    xfer_en <= 1'b0;
    @(posedge lclk);
    sclk <= 1'b0;
    repeat (90) @(posedge lclk);
  endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the elapsed counter port
// assumes the host model and the bound checker
`timescale 1ns/1ps
module tb_top;
  import elapsed_counter_pkg::*;
  localparam int PRE = 4;
  logic              clk_sys = 1'b0;
  logic              lclk = 1'b0;
  logic              srst, access_inhibit, vcc_valid, crystal_in;
  logic              xfer_en, sclk, dq_in, dq_out, dq_oe, evt_overflow;
  logic [TRIM_W-1:0] osc_trim, et;
  logic [CNT_W-1:0]  cont_count, pwr_count, ec, ep, rd, d;
  logic [7:0]        c;
  int                n_mismatch = 0;
  int                n_checks = 0;
  always #4 clk_sys = ~clk_sys;
  always #6 lclk = ~lclk;
  elapsed_counter_port #(.PRESCALE_CNT(PRE), .FIFO_DEPTH(32)) dut (
    .clk_sys(clk_sys), .srst(srst), .xfer_en(xfer_en), .sclk(sclk),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .access_inhibit(access_inhibit), .vcc_valid(vcc_valid),
    .crystal_in(crystal_in), .osc_trim(osc_trim), .cont_count(cont_count),
    .pwr_count(pwr_count), .evt_overflow(evt_overflow));
  ecp_host h (.lclk(lclk), .xfer_en(xfer_en), .sclk(sclk), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  // =====================================================================
  // checking and expectations
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic void predict(logic [7:0] k, logic [31:0] v, int nd);
    if (access_inhibit)
      return;
    case (k[7:6])
      2'b00: begin
        if (k[2]) ec = '0;
        if (k[1]) ep = '0;
      end
      2'b11: if (!k[0]) et = k[5:3];
      default: if (!k[0] && nd == 32) begin
        if (k[7]) ec = v;
        else ep = v;
      end
    endcase
  endfunction
  task automatic cmp_all();
    check("cont", cont_count, ec);
    check("pwr", pwr_count, ep);
    check("trim", osc_trim, et);
    check("overflow", evt_overflow, 1'b0);
  endtask
  task automatic run(input logic [7:0] k, input logic [31:0] v, input int nd);
    logic [31:0] want;
    want = k[7] ? ec : ep;
    h.frame(k, v, nd, rd);
    if (k[0] && ^k[7:6] && nd == 32 && !access_inhibit)
      check("read data", rd, want);
    predict(k, v, nd);
    cmp_all();
  endtask
  task automatic tick(input int n, input int dc, input int dp);
    repeat (2 * n * PRE) begin
      repeat (4) @(posedge clk_sys);
      crystal_in <= ~crystal_in;
    end
    repeat (16) @(posedge clk_sys);
    ec = ec + dc;
    ep = ep + dp;
    cmp_all();
  endtask
  task automatic do_reset();
    @(posedge clk_sys) srst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ec = '0;
    ep = '0;
    et = 3'h3;
    cmp_all();
  endtask
  // =====================================================================
  // main sequence and watchdog
  initial begin
    srst = 1'b1;
    access_inhibit = 1'b0;
    vcc_valid = 1'b1;
    crystal_in = 1'b0;
    d = $urandom(13);
    do_reset();
    run(8'h00, '0, 0);
    for (int i = 0; i < 6; i++) begin
      c = (8'($urandom) & 8'h3e) | (i[0] ? 8'h80 : 8'h40);
      run(c, $urandom, 32);
      run(c | 8'h01, '0, 32);
    end
    for (int t = 0; t < 8; t++)
      run({2'b11, 3'(t), 3'b110}, '0, 0);
    run(8'hff, '0, 32);
    run(8'h04, '0, 0);
    run(8'h02, '0, 0);
    run(8'h84, 32'h8000_0001, 32);
    run(8'h06, '0, 0);
    run(8'h40, 32'h1234_5678, 20);
    h.half_n = 20;
    run(8'h81, '0, 32);
    h.half_n = 8;
    @(posedge clk_sys) access_inhibit <= 1'b1;
    run(8'h80, 32'hdead_beef, 32);
    run(8'h41, '0, 32);
    @(posedge clk_sys) access_inhibit <= 1'b0;
    @(posedge clk_sys) vcc_valid <= 1'b0;
    tick(3, 3, 0);
    @(posedge clk_sys) vcc_valid <= 1'b1;
    tick(2, 2, 2);
    run(8'hc0, '0, 0);
    tick(2, 0, 0);
    do_reset();
    final_report();
  end
  initial begin
    #600us;
    n_mismatch++;
    final_report();
  end
endmodule
